// ---- hdl/pls_pll_seq.sv ----
/*
  PLL power-up and lock sequencer with an AHB-Lite register slave.
  Assumes boot select pins, lock inputs and bus are synchronous to hclk;
  hready is this slave's own hreadyout.

*/
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ns
module pls_pll_seq
  import pls_pkg::*;
#(
  parameter int BOOT_W = PLS_BOOT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [BOOT_W-1:0] boot_select_pins,
  input wire logic [2:0] pll_lock_in,
  output logic [2:0] pll_power_down_out,
  output logic main_pll_mode_out,
  output logic sys_clk_sel_pll_out,
  output logic main_pll_lock_out,
  output logic memory_pll_lock_out,
  output logic packet_pll_lock_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pls_state_type state_reg, state_next;
  logic [BOOT_W-1:0] boot_reg, boot_next;
  logic [31:0] pll_control_reg, pll_control_next;
  logic pd_done_reg, pd_done_next;
  logic pd_short_reg, pd_short_next;
  logic [2:0] pd_out_reg, pd_out_next;
  logic mode_reg, mode_next;
  logic clksel_reg, clksel_next;
  logic [2:0] lock_reg;
  logic pend_reg, pend_next;
  logic pwrite_reg, pwrite_next;
  logic [31:0] paddr_reg, paddr_next;
  logic rdy_reg, rdy_next;
  logic [31:0] rdata_reg, rdata_next;
  logic accept;
  logic sw_mode;
  pls_pd_if pd_bus ();

  function automatic logic is_bypass_boot(input logic [BOOT_W-1:0] m);
    is_bypass_boot = (m == PLS_BOOT_NONE) || (m == PLS_BOOT_SPI) ||
                     (m == PLS_BOOT_I2C);
  endfunction

  function automatic logic [31:0] status_word(
    input logic [2:0] lk,
    input logic sel,
    input logic done,
    input logic shrt,
    input logic [BOOT_W-1:0] bm,
    input logic [4:0] st
  );
    status_word = '0;
    status_word[PLS_STAT_LOCK_LSB +: 3] = lk;
    status_word[PLS_STAT_PLLCLK_BIT] = sel;
    status_word[PLS_STAT_PDDONE_BIT] = done;
    status_word[PLS_STAT_PDSHORT_BIT] = shrt;
    status_word[PLS_STAT_BOOT_LSB +: BOOT_W] = bm;
    status_word[PLS_STAT_STATE_LSB +: 5] = st;
  endfunction

  // ----------------------------------------------------------------
  // Power-down pulse monitor
  // ----------------------------------------------------------------
  assign pd_bus.pd_level = pll_control_reg[PLS_CTRL_PD_BIT];

  pls_pd_pulse_mon #(
    .MIN_CYC(PLS_PD_MIN_CYC),
    .CNT_W(PLS_PD_CNT_W)
  ) u_pd_mon (
    .hclk(hclk),
    .hresetn(hresetn),
    .pd(pd_bus.mon)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave: one wait state in every data phase
  // ----------------------------------------------------------------
  assign accept = hsel && htrans[1] && hready;

  always_comb begin
    pend_next = pend_reg;
    pwrite_next = pwrite_reg;
    paddr_next = paddr_reg;
    rdy_next = rdy_reg;
    rdata_next = rdata_reg;
    pll_control_next = pll_control_reg;
    if (accept) begin
      pend_next = 1'b1;
      pwrite_next = hwrite;
      paddr_next = haddr;
      rdy_next = 1'b0;
    end else if (pend_reg) begin
      pend_next = 1'b0;
      rdy_next = 1'b1;
      rdata_next = '0;
      if (pwrite_reg) begin
        // Only mode and power-down bits are stored; others read zero
        if (paddr_reg == PLS_CTRL_ADDR) begin
          pll_control_next[PLS_CTRL_MODE_BIT] = hwdata[PLS_CTRL_MODE_BIT];
          pll_control_next[PLS_CTRL_PD_BIT] = hwdata[PLS_CTRL_PD_BIT];
        end
      end else if (paddr_reg == PLS_CTRL_ADDR) begin
        rdata_next = pll_control_reg;
      end else if (paddr_reg == PLS_STAT_ADDR) begin
        rdata_next = status_word(lock_reg, clksel_reg, pd_done_reg,
                                 pd_short_reg, boot_reg, state_reg);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= 1'b0;
      pwrite_reg <= 1'b0;
      paddr_reg <= '0;
      rdy_reg <= 1'b1;
      rdata_reg <= '0;
      pll_control_reg <= PLS_CTRL_RESET;
    end else begin
      pend_reg <= pend_next;
      pwrite_reg <= pwrite_next;
      paddr_reg <= paddr_next;
      rdy_reg <= rdy_next;
      rdata_reg <= rdata_next;
      pll_control_reg <= pll_control_next;
    end
  end

  assign hreadyout = rdy_reg;
  assign hrdata = rdata_reg;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign sw_mode = pll_control_reg[PLS_CTRL_MODE_BIT];

  always_comb begin
    state_next = state_reg;
    boot_next = boot_reg;
    mode_next = mode_reg;
    clksel_next = clksel_reg;
    // Event set wins over the clear at a new pulse start
    pd_done_next = pd_done_reg;
    pd_short_next = pd_short_reg;
    if (pll_control_reg[PLS_CTRL_PD_BIT]) begin
      pd_done_next = 1'b0;
    end
    if (pd_bus.pulse_ok) begin
      pd_done_next = 1'b1;
      pd_short_next = 1'b0;
    end
    if (pd_bus.pulse_short) begin
      pd_short_next = 1'b1;
    end
    // One control bit powers down all three PLLs together
    pd_out_next = {3{pll_control_reg[PLS_CTRL_PD_BIT]}};
    unique case (state_reg)
      ST_BOOT: begin
        boot_next = boot_select_pins;
        state_next = is_bypass_boot(boot_select_pins) ? ST_BYPASS :
                     ST_PDWAIT;
      end
      ST_BYPASS: begin
        mode_next = 1'b0;
        clksel_next = 1'b0;
        if (sw_mode && pd_done_reg) begin
          state_next = ST_LOCKWAIT;
        end
      end
      ST_PDWAIT: begin
        // Init waits for a completed power-down pulse
        if (pd_done_reg) begin
          state_next = ST_LOCKWAIT;
        end
      end
      ST_LOCKWAIT: begin
        mode_next = 1'b1;
        clksel_next = 1'b0;
        if (pll_control_reg[PLS_CTRL_PD_BIT] ||
            (is_bypass_boot(boot_reg) && !sw_mode)) begin
          mode_next = 1'b0;
          state_next = is_bypass_boot(boot_reg) ? ST_BYPASS : ST_PDWAIT;
        end else if (mode_reg && lock_reg[0]) begin
          // Lock counts only once PLL mode is already requested
          clksel_next = 1'b1;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!lock_reg[0] || pll_control_reg[PLS_CTRL_PD_BIT] ||
            (is_bypass_boot(boot_reg) && !sw_mode)) begin
          // Drop back to bypass clock while the PLL is unusable
          clksel_next = 1'b0;
          state_next = ST_LOCKWAIT;
        end
      end
      default: begin
        state_next = ST_BOOT;
        mode_next = 1'b0;
        clksel_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_BOOT;
      boot_reg <= '0;
      mode_reg <= 1'b0;
      clksel_reg <= 1'b0;
      pd_done_reg <= 1'b0;
      pd_short_reg <= 1'b0;
      pd_out_reg <= '0;
    end else begin
      state_reg <= state_next;
      boot_reg <= boot_next;
      mode_reg <= mode_next;
      clksel_reg <= clksel_next;
      pd_done_reg <= pd_done_next;
      pd_short_reg <= pd_short_next;
      pd_out_reg <= pd_out_next;
    end
  end

  // ----------------------------------------------------------------
  // Lock status outputs
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < 3; i++) begin : g_lock
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          lock_reg[i] <= 1'b0;
        end else begin
          lock_reg[i] <= pll_lock_in[i];
        end
      end
    end
  endgenerate

  assign pll_power_down_out = pd_out_reg;
  assign main_pll_mode_out = mode_reg;
  assign sys_clk_sel_pll_out = clksel_reg;
  assign main_pll_lock_out = lock_reg[0];
  assign memory_pll_lock_out = lock_reg[1];
  assign packet_pll_lock_out = lock_reg[2];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_boot_sample:
  assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && state_reg == ST_BOOT |=> boot_reg == $past(boot_select_pins))
  else $error("boot mode not sampled at reset release");

  a_bypass_kept:
  assert property (@(posedge hclk) disable iff (!hresetn)
    is_bypass_boot(boot_reg) && !sw_mode && state_reg != ST_BOOT
    |-> ##2 !main_pll_mode_out && !sys_clk_sel_pll_out)
  else $error("bypass boot mode left bypass without request");

  a_auto_init:
  assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_PDWAIT && pd_done_reg
    |=> state_reg == ST_LOCKWAIT ##1 main_pll_mode_out)
  else $error("PLL initialisation did not start");

  a_pd_first:
  assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(main_pll_mode_out) |-> $past(pd_done_reg, 2))
  else $error("PLL mode requested before power-down pulse");

  a_pd_all_plls:
  assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(pll_control_reg[PLS_CTRL_PD_BIT]) |=> pll_power_down_out == 3'h7)
  else $error("power-down not applied to all PLLs");

  a_lock_follow:
  assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn |=> {packet_pll_lock_out, memory_pll_lock_out, main_pll_lock_out}
      == $past(pll_lock_in))
  else $error("lock outputs do not follow PLL locks");

  a_clk_after_lock:
  assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(sys_clk_sel_pll_out)
    |-> main_pll_mode_out && $past(main_pll_lock_out))
  else $error("clock switched to PLL before lock");

  a_bus_wait:
  assert property (@(posedge hclk) disable iff (!hresetn)
    accept |=> !hreadyout ##1 hreadyout)
  else $error("data phase not exactly one wait state");

endmodule // pls_pll_seq

// ---- hdl/pls_pkg.sv ----
/*
  Package of the PLL power-up and lock sequencer: register map, field
  positions, reset values, boot codes and timing counts.
  Assumes a 20 MHz hclk.
*/
package pls_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] PLS_CTRL_ADDR = 32'h0231_0100;
  localparam logic [31:0] PLS_STAT_ADDR = 32'h0231_0104;
  localparam logic [31:0] PLS_CTRL_RESET = 32'h0000_0000;

  // Control fields
  localparam int PLS_CTRL_MODE_BIT = 0;
  localparam int PLS_CTRL_PD_BIT = 1;

  // Status fields
  localparam int PLS_STAT_LOCK_LSB = 0;
  localparam int PLS_STAT_PLLCLK_BIT = 3;
  localparam int PLS_STAT_PDDONE_BIT = 4;
  localparam int PLS_STAT_PDSHORT_BIT = 5;
  localparam int PLS_STAT_BOOT_LSB = 8;
  localparam int PLS_STAT_STATE_LSB = 16;

  // ----------------------------------------------------------------
  // Boot modes
  // ----------------------------------------------------------------
  localparam int PLS_BOOT_W = 3;
  localparam logic [2:0] PLS_BOOT_NONE = 3'h0;
  localparam logic [2:0] PLS_BOOT_SPI = 3'h1;
  localparam logic [2:0] PLS_BOOT_I2C = 3'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PLS_CLK_PERIOD_NS = 50;
  localparam int PLS_PD_MIN_NS = 5000;
  localparam int PLS_PD_MIN_CYC =
    (PLS_PD_MIN_NS + PLS_CLK_PERIOD_NS - 1) / PLS_CLK_PERIOD_NS;
  localparam int PLS_PD_CNT_W = 8;

  typedef enum logic [4:0] {
    ST_BOOT = 5'h01,
    ST_BYPASS = 5'h02,
    ST_PDWAIT = 5'h04,
    ST_LOCKWAIT = 5'h08,
    ST_RUN = 5'h10
  } pls_state_type;

endpackage

// ---- hdl/pls_pd_if.sv ----
/*
  Interface between the sequencer and its power-down pulse monitor.
  Assumes both ends run on the same hclk.
*/
`timescale 1ns/1ns
interface pls_pd_if;
  logic pd_level;
  logic pulse_ok;
  logic pulse_short;
  modport mon (input pd_level, output pulse_ok, output pulse_short);
  modport ctl (output pd_level, input pulse_ok, input pulse_short);
endinterface

// ---- hdl/pls_pd_pulse_mon.sv ----
/*
  Power-down pulse monitor: measures how long the power-down bit stays
  set and reports, at its fall, whether the pulse was long enough.
  Assumes pd_level is a flop output on hclk.
*/
`timescale 1ns/1ns
module pls_pd_pulse_mon
  import pls_pkg::*;
#(
  parameter int MIN_CYC = PLS_PD_MIN_CYC,
  parameter int CNT_W = PLS_PD_CNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  pls_pd_if.mon pd
);

  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic prev_reg, prev_next;
  logic ok_reg, ok_next;
  logic short_reg, short_next;
  logic fall;

  // ----------------------------------------------------------------
  // Width count
  // ----------------------------------------------------------------
  always_comb begin
    fall = prev_reg && !pd.pd_level;
    prev_next = pd.pd_level;
    cnt_next = cnt_reg;
    if (!pd.pd_level) begin
      cnt_next = '0;
    end else if (cnt_reg != {CNT_W{1'b1}}) begin
      cnt_next = cnt_reg + 1'b1;
    end
    ok_next = fall && (int'(cnt_reg) >= MIN_CYC);
    short_next = fall && (int'(cnt_reg) < MIN_CYC);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      prev_reg <= 1'b0;
      ok_reg <= 1'b0;
      short_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      prev_reg <= prev_next;
      ok_reg <= ok_next;
      short_reg <= short_next;
    end
  end

  assign pd.pulse_ok = ok_reg;
  assign pd.pulse_short = short_reg;

  a_pulse_min_width:
  assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(pd.pd_level) && (int'(cnt_reg) < MIN_CYC) |=> !pd.pulse_ok)
  else $error("short power-down pulse reported as good");

endmodule // pls_pd_pulse_mon

// ---- tb/pls_pll_seq_tb.sv ----
/*
  Self-checking bench of the PLL power-up and lock sequencer.
  Assumes hready is tied to the slave's hreadyout and a 20 MHz hclk.
*/
`timescale 1ns/1ns
module pls_pll_seq_tb
  import pls_pkg::*;
;
  typedef struct {
    logic [2:0] boot;
    logic [4:0] st;
  } pls_row_type;

  logic hclk = 1'b0;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [2:0] boot_pins;
  logic [2:0] lock_in;
  logic [2:0] pd_out;
  logic mode_out;
  logic clk_sel;
  logic lk_main;
  logic lk_mem;
  logic lk_pkt;
  logic [31:0] rd;
  int bad_count;
  int num_checks;
  pls_row_type rows [8] = '{'{3'h0, ST_BYPASS}, '{3'h1, ST_BYPASS},
    '{3'h2, ST_BYPASS}, '{3'h3, ST_PDWAIT}, '{3'h4, ST_PDWAIT},
    '{3'h5, ST_PDWAIT}, '{3'h6, ST_PDWAIT}, '{3'h7, ST_PDWAIT}};

  always #25 hclk = ~hclk;

  pls_pll_seq u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .boot_select_pins(boot_pins), .pll_lock_in(lock_in),
    .pll_power_down_out(pd_out), .main_pll_mode_out(mode_out),
    .sys_clk_sel_pll_out(clk_sel), .main_pll_lock_out(lk_main),
    .memory_pll_lock_out(lk_mem), .packet_pll_lock_out(lk_pkt)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task timed_out;
    bad_count++;
    $display("ERROR %0t wait ran out", $time);
    report_and_stop();
  endtask

  // Waits for hready high at a rising edge
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      timed_out();
    end
  endtask

  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  // Polls the clock select (sel high) or the PLL-mode output
  task wait_out(input logic sel);
    int n;
    n = 0;
    while ((sel ? clk_sel : mode_out) !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 200) begin
      timed_out();
    end
  endtask

  task do_reset(input logic [2:0] b);
    @(posedge hclk);
    hresetn <= 1'b0;
    boot_pins <= b;
    lock_in <= 3'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // Power-down bit high for exactly n cycles (two writes add four)
  task pd_hold(input int n);
    ahb(1'b1, PLS_CTRL_ADDR, 32'h2);
    repeat (n - 4) @(posedge hclk);
    ahb(1'b1, PLS_CTRL_ADDR, 32'h0);
  endtask

  // Power-down pulse by read-modify-write, held eight cycles past the minimum time
  task pd_pulse;
    ahb(1'b0, PLS_CTRL_ADDR, 32'h0);
    ahb(1'b1, PLS_CTRL_ADDR, rd | 32'h2);
    repeat (PLS_PD_MIN_CYC) @(posedge hclk);
    ahb(1'b0, PLS_CTRL_ADDR, 32'h0);
    chk(rd & 32'h2, 32'h2);
    ahb(1'b1, PLS_CTRL_ADDR, rd & ~32'h2);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    boot_pins = 3'h0;
    lock_in = 3'h0;
    bad_count = 0;
    num_checks = 0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk({hreadyout, hresp, pd_out, mode_out, clk_sel, lk_main, lk_mem,
      lk_pkt}, 32'h200);
    chk(hrdata, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      do_reset(rows[i].boot);
      @(posedge hclk);
      boot_pins <= ~rows[i].boot;
      ahb(1'b0, PLS_STAT_ADDR, 32'h0);
      chk(rd, {11'h0, rows[i].st, 5'h0, rows[i].boot, 8'h00});
      chk({hresp, mode_out, clk_sel}, 32'h0);
    end
    $display("test boot table done");

    ahb(1'b0, PLS_CTRL_ADDR, 32'h0);
    chk(rd, PLS_CTRL_RESET);
    ahb(1'b1, PLS_CTRL_ADDR, 32'hFFFF_FFFC);
    ahb(1'b1, 32'h0231_0108, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0231_0108, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, PLS_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");

    ahb(1'b1, PLS_CTRL_ADDR, 32'h2);
    @(negedge hclk);
    chk(pd_out, 32'h7);
    ahb(1'b1, PLS_CTRL_ADDR, 32'h0);
    repeat (4) @(posedge hclk);
    ahb(1'b0, PLS_STAT_ADDR, 32'h0);
    chk(rd[5:3], 32'h4);
    chk(rd[20:16], ST_PDWAIT);
    chk({pd_out, mode_out}, 32'h0);
    $display("test short pulse done");

    pd_hold(PLS_PD_MIN_CYC - 1);
    ahb(1'b0, PLS_STAT_ADDR, 32'h0);
    chk(rd[5:4], 32'h2);
    pd_hold(PLS_PD_MIN_CYC);
    ahb(1'b0, PLS_STAT_ADDR, 32'h0);
    chk(rd[5:4], 32'h1);
    $display("test pulse limit done");

    pd_pulse();
    wait_out(1'b0);
    @(negedge hclk);
    chk(clk_sel, 32'h0);
    @(posedge hclk);
    lock_in <= 3'h2;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk({lk_pkt, lk_mem, lk_main, clk_sel}, 32'h4);
    @(posedge hclk);
    lock_in <= 3'h5;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk({lk_pkt, lk_mem, lk_main, clk_sel}, 32'hB);
    ahb(1'b0, PLS_STAT_ADDR, 32'h0);
    chk(rd[20:16], ST_RUN);
    chk(rd[4:0], 32'h1D);
    @(posedge hclk);
    lock_in <= 3'h4;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk({lk_main, clk_sel}, 32'h0);
    $display("test main boot sequence done");

    do_reset(3'h1);
    ahb(1'b1, PLS_CTRL_ADDR, 32'h1);
    repeat (10) @(posedge hclk);
    @(negedge hclk);
    chk(mode_out, 32'h0);
    pd_pulse();
    ahb(1'b0, PLS_CTRL_ADDR, 32'h0);
    chk(rd, 32'h1);
    wait_out(1'b0);
    @(posedge hclk);
    lock_in <= 3'h7;
    wait_out(1'b1);
    @(negedge hclk);
    chk({lk_pkt, lk_mem, lk_main, mode_out}, 32'hF);
    $display("test bypass boot sequence done");
    report_and_stop();
  end
endmodule // pls_pll_seq_tb
